//--- common/supply_pkg.sv
package supply_pkg;

    localparam int    NUM_CH           = 4;
    localparam int    CLK_PERIOD_NS    = 10;
    // fail-mode input deglitch time in microseconds
    localparam int    FAIL_DGL_US      = 200;
    localparam int    FAIL_DGL_CYCLES  = (FAIL_DGL_US * 1000) / CLK_PERIOD_NS;
    localparam int    CNT_W            = 16;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    // status word bit positions
    localparam int    ST_FAIL_IN_BIT   = 0;
    localparam int    ST_SPI_FAIL_BIT  = 1;
    localparam int    ST_W             = 2;
    // fault vector bit positions
    localparam int    F_OPEN_LOAD      = 0;
    localparam int    F_SHORT_BAT      = 1;
    localparam int    F_SHORT_GND      = 2;
    localparam int    F_OVERCURRENT    = 3;
    localparam int    F_OVERTEMP       = 4;
    localparam int    F_CLOCK_FAIL     = 5;
    localparam int    F_UNDERVOLT      = 6;
    localparam int    F_OVERVOLT       = 7;
    localparam int    FAULT_W          = 8;
    localparam logic [FAULT_W-1:0] FAULT_RESET = 8'h00;

    typedef enum logic [2:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_FAIL,
        MODE_BAT_LOSS,
        MODE_POWER_OFF
    } mode_t;

endpackage

//--- common/pin_sync_if.sv
`timescale 1ns/1ns
interface pin_sync_if;
    logic                           reset_n_s;
    logic                           fail_in_s;
    logic [supply_pkg::NUM_CH-1:0]  direct_s;

    modport producer (output reset_n_s, output fail_in_s, output direct_s);
    modport consumer (input reset_n_s, input fail_in_s, input direct_s);
endinterface

//--- hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          srst,
    // raw pins
    input  wire logic                          active_low_reset_pin,
    input  wire logic                          fail_mode_in,
    input  wire logic [supply_pkg::NUM_CH-1:0] direct_channel_inputs,
    // synchronised copies
    pin_sync_if.producer                       sync
);
    localparam int W = supply_pkg::NUM_CH + 2;

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            stage1_reg <= {W{1'b1}} & {{(W-1){1'b0}}, 1'b1};
            stage2_reg <= {{(W-1){1'b0}}, 1'b1};
        end else begin
            stage1_reg <= {direct_channel_inputs, fail_mode_in, active_low_reset_pin};
            stage2_reg <= stage1_reg;
        end
    end

    assign sync.reset_n_s = stage2_reg[0];
    assign sync.fail_in_s = stage2_reg[1];
    assign sync.direct_s  = stage2_reg[W-1:2];
endmodule // pin_sync

//--- hdl/supply_mode_ctrl.sv
`timescale 1ns/1ns
module supply_mode_ctrl (
    // clock and reset
    input  wire logic                               mclk,
    input  wire logic                               srst,
    // power state
    input  wire logic                               wake,
    input  wire logic                               wake_by_reset_pin,
    input  wire logic                               bat_ok,
    input  wire logic                               logic_supply_ok,
    input  wire logic                               gnd_ok,
    // host pins
    input  wire logic                               active_low_reset_pin,
    input  wire logic                               fail_mode_in,
    input  wire logic [supply_pkg::NUM_CH-1:0]      direct_channel_inputs,
    output logic                                    clk_pin_out,
    output logic                                    clk_pin_oe,
    // spi side
    input  wire logic                               spi_error,
    input  wire logic [supply_pkg::NUM_CH-1:0]      pwm_channels,
    input  wire logic                               ext_switch_setting,
    input  wire logic [supply_pkg::FAULT_W-1:0]     fault_events,
    output logic [supply_pkg::FAULT_W-1:0]          fault_status,
    output logic [supply_pkg::ST_W-1:0]             device_status,
    output logic                                    readback_enable,
    output logic                                    spi_watchdog_timeout,
    // outputs
    output logic [supply_pkg::NUM_CH-1:0]           power_channel_outputs,
    output logic                                    external_switch_control_output,
    output supply_pkg::mode_t                       mode
);
    pin_sync_if sync ();

    pin_sync i_pin_sync (
        .mclk                  (mclk),
        .srst                  (srst),
        .active_low_reset_pin  (active_low_reset_pin),
        .fail_mode_in          (fail_mode_in),
        .direct_channel_inputs (direct_channel_inputs),
        .sync                  (sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [supply_pkg::CNT_W-1:0] dgl_cnt_reg;
    logic                         fail_req_reg;
    logic                         spi_fail_reg;
    logic                         power_off;
    logic                         bat_loss;
    logic                         vcc_loss;
    logic                         spi_lost;
    logic                         dgl_clear;
    logic                         dgl_done;
    logic                         channels_off;
    logic                         ext_follow;

    assign power_off = (!bat_ok && !logic_supply_ok);
    assign bat_loss  = !bat_ok && logic_supply_ok;
    assign vcc_loss  = bat_ok && !logic_supply_ok;
    // a dead logic supply leaves the spi unusable, same as a comms error
    assign spi_lost  = spi_error || vcc_loss;
    // channels are cut one cycle after battery loss, power off or ground loss, not after logic supply loss alone
    assign channels_off = power_off || bat_loss || !gnd_ok;

    // any low sample of the synced fail input restarts the deglitch window
    assign dgl_clear = srst || power_off || !sync.fail_in_s;
    assign dgl_done  = dgl_cnt_reg >= supply_pkg::CNT_W'(supply_pkg::FAIL_DGL_CYCLES);

    // deglitch counter saturates at the window length
    always_ff @(posedge mclk) begin
        if (dgl_clear) begin
            dgl_cnt_reg <= supply_pkg::CNT_RESET;
        end else if (!dgl_done) begin
            dgl_cnt_reg <= dgl_cnt_reg + 1'b1;
        end
    end

    // deglitched fail request
    always_ff @(posedge mclk) begin
        if (dgl_clear) begin
            fail_req_reg <= 1'b0;
        end else if (dgl_done) begin
            fail_req_reg <= 1'b1;
        end
    end

    // spi failure latched on any spi loss, released once in fail mode with no deglitched fail request
    always_ff @(posedge mclk) begin
        if (srst || power_off) begin
            spi_fail_reg <= 1'b0;
        end else if (spi_lost) begin
            spi_fail_reg <= 1'b1;
        end else if (mode == supply_pkg::MODE_FAIL && !fail_req_reg) begin
            spi_fail_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode priority: power off, battery loss, sleep, fail, normal
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode <= supply_pkg::MODE_POWER_OFF;
        end else if (power_off) begin
            mode <= supply_pkg::MODE_POWER_OFF;
        end else if (bat_loss) begin
            mode <= supply_pkg::MODE_BAT_LOSS;
        end else if (!wake) begin
            mode <= supply_pkg::MODE_SLEEP;
        end else if (fail_req_reg || spi_fail_reg || spi_lost) begin
            mode <= supply_pkg::MODE_FAIL;
        end else begin
            mode <= supply_pkg::MODE_NORMAL;
        end
    end

    // channel outputs
    always_ff @(posedge mclk) begin
        if (srst || channels_off) begin
            power_channel_outputs <= '0;
        end else begin
            case (mode)
                supply_pkg::MODE_NORMAL: power_channel_outputs <= pwm_channels;
                supply_pkg::MODE_FAIL:   power_channel_outputs <= sync.direct_s;
                default:                 power_channel_outputs <= '0;
            endcase
        end
    end

    assign ext_follow = bat_loss || mode == supply_pkg::MODE_NORMAL
                        || mode == supply_pkg::MODE_BAT_LOSS;

    // external switch follows its spi setting in normal mode and battery loss
    always_ff @(posedge mclk) begin
        if (srst || power_off || !logic_supply_ok) begin
            external_switch_control_output <= 1'b0;
        end else if (ext_follow) begin
            external_switch_control_output <= ext_switch_setting;
        end else begin
            external_switch_control_output <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // faults kept through battery loss, cleared at power off
    always_ff @(posedge mclk) begin
        if (srst || power_off) begin
            fault_status <= supply_pkg::FAULT_RESET;
        end else begin
            fault_status <= fault_status | fault_events;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || power_off) begin
            device_status <= '0;
        end else begin
            device_status[supply_pkg::ST_FAIL_IN_BIT]  <= sync.fail_in_s;
            device_status[supply_pkg::ST_SPI_FAIL_BIT] <= spi_fail_reg;
        end
    end

    // readback needs the logic supply
    always_ff @(posedge mclk) begin
        if (srst) begin
            readback_enable <= 1'b0;
        end else begin
            readback_enable <= logic_supply_ok && !power_off;
        end
    end

    // logic supply lost while the battery is ok is seen by the spi side as a watchdog timeout
    always_ff @(posedge mclk) begin
        if (srst) begin
            spi_watchdog_timeout <= 1'b0;
        end else begin
            spi_watchdog_timeout <= vcc_loss;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wake report: reset pin low, awake, not woken by that pin, both supplies up
    function automatic logic wake_report(input logic rst_n_s, input logic awake,
                                         input logic by_pin, input logic vbat,
                                         input logic vlogic);
        return !rst_n_s && awake && !by_pin && vbat && vlogic;
    endfunction

    // level driven onto the clock pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_pin_out <= 1'b0;
        end else begin
            clk_pin_out <= wake_report(sync.reset_n_s, wake, wake_by_reset_pin,
                                       bat_ok, logic_supply_ok);
        end
    end

    // pin stays an input unless the wake state is being reported
    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_pin_oe <= 1'b0;
        end else begin
            clk_pin_oe <= wake_report(sync.reset_n_s, wake, wake_by_reset_pin,
                                      bat_ok, logic_supply_ok);
        end
    end
endmodule // supply_mode_ctrl

//--- dv/smc_props.sv
`timescale 1ns/1ns
module smc_props (
    // clock and reset
    input wire logic                mclk,
    input wire logic                srst,
    // supplies and pins
    input wire logic                wake,
    input wire logic                bat_ok,
    input wire logic                logic_supply_ok,
    input wire logic                gnd_ok,
    input wire logic                fail_mode_in,
    input wire logic                spi_error,
    // outputs
    input wire logic                clk_pin_oe,
    input wire logic [7:0]          fault_status,
    input wire logic [1:0]          device_status,
    input wire logic                readback_enable,
    input wire logic                spi_watchdog_timeout,
    input wire logic [3:0]          power_channel_outputs,
    input wire supply_pkg::mode_t   mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    property p_sleep; (!wake && bat_ok && logic_supply_ok) |=> mode == supply_pkg::MODE_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_rb; !logic_supply_ok [*2] |=> !readback_enable; endproperty
    a_rb: assert property (p_rb) else $error("readback on");
    property p_off; (!bat_ok && !logic_supply_ok) |=>
        mode == supply_pkg::MODE_POWER_OFF ##1 fault_status == 8'h00; endproperty
    a_off: assert property (p_off) else $error("no power off");
    property p_bat; !bat_ok |=> power_channel_outputs == 4'h0; endproperty
    a_bat: assert property (p_bat) else $error("channels on");
    property p_clkbat; !bat_ok [*2] |=> !clk_pin_oe; endproperty
    a_clkbat: assert property (p_clkbat) else $error("clock pin driven");
    property p_wdt; ($fell(logic_supply_ok) && bat_ok) |-> ##[1:3] spi_watchdog_timeout;
    endproperty
    a_wdt: assert property (p_wdt) else $error("no timeout");
    property p_gnd; !gnd_ok |=> power_channel_outputs == 4'h0; endproperty
    a_gnd: assert property (p_gnd) else $error("channels on");
    property p_spif; ($rose(spi_error) && wake && bat_ok && logic_supply_ok) |->
        ##[1:3] mode == supply_pkg::MODE_FAIL; endproperty
    a_spif: assert property (p_spif) else $error("no fail mode");
    property p_stat; $stable(fail_mode_in) [*5] |-> device_status[0] == fail_mode_in;
    endproperty
    a_stat: assert property (p_stat) else $error("status bit");
endmodule // smc_props
bind supply_mode_ctrl smc_props i_smc_props (.mclk(mclk), .srst(srst), .wake(wake),
    .bat_ok(bat_ok), .logic_supply_ok(logic_supply_ok), .gnd_ok(gnd_ok),
    .fail_mode_in(fail_mode_in), .spi_error(spi_error), .clk_pin_oe(clk_pin_oe),
    .fault_status(fault_status), .device_status(device_status),
    .readback_enable(readback_enable), .spi_watchdog_timeout(spi_watchdog_timeout),
    .power_channel_outputs(power_channel_outputs), .mode(mode));

//--- dv/host_model.sv
`timescale 1ns/1ns
module host_model (
    // clock
    input wire logic    mclk,
    // clock pin
    input wire logic    clk_pin_out,
    input wire logic    clk_pin_oe,
    output logic        clk_level,
    // host pins
    output logic        active_low_reset_pin = 1'h1,
    output logic        fail_mode_in = 1'h0,
    output logic [3:0]  direct_channel_inputs = 4'h0
);
    // released pin settles low through the host pull-down
    assign clk_level = clk_pin_oe ? clk_pin_out : 1'h0;
    task automatic drive(input logic rst_n, input logic fail, input logic [3:0] dir);
        @(posedge mclk);
        active_low_reset_pin <= rst_n;
        fail_mode_in <= fail;
        direct_channel_inputs <= dir;
    endtask
endmodule // host_model

//--- dv/supply_and_fail_mode_control_bench.sv
`timescale 1ns/1ns
module supply_and_fail_mode_control_bench;
    logic mclk = 1'h0, srst = 1'h1, wake = 1'h1, by_rst = 1'h0, bat = 1'h1, vcc = 1'h1;
    logic gnd = 1'h1, spi_err = 1'h0, ext_set = 1'h1, rst_n, fail_in, c_out, c_oe, c_lvl;
    logic rb, wdt, ext;
    logic [3:0] pwm = 4'h5, dir, pco;
    logic [7:0] fev = 8'h00, fst;
    logic [1:0] dst;
    supply_pkg::mode_t mode;
    int err_total = 0;
    int comparisons = 0;
    always #5 mclk = ~mclk;
    host_model i_host_model (.mclk(mclk), .clk_pin_out(c_out), .clk_pin_oe(c_oe),
        .clk_level(c_lvl), .active_low_reset_pin(rst_n), .fail_mode_in(fail_in),
        .direct_channel_inputs(dir));
    supply_mode_ctrl i_supply_mode_ctrl (.mclk(mclk), .srst(srst), .wake(wake),
        .wake_by_reset_pin(by_rst), .bat_ok(bat), .logic_supply_ok(vcc), .gnd_ok(gnd),
        .active_low_reset_pin(rst_n), .fail_mode_in(fail_in), .direct_channel_inputs(dir),
        .clk_pin_out(c_out), .clk_pin_oe(c_oe), .spi_error(spi_err), .pwm_channels(pwm),
        .ext_switch_setting(ext_set), .fault_events(fev), .fault_status(fst),
        .device_status(dst), .readback_enable(rb), .spi_watchdog_timeout(wdt),
        .power_channel_outputs(pco), .external_switch_control_output(ext), .mode(mode));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic end_sim;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_mode(input supply_pkg::mode_t m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) step(1);
        chk(8'(mode), 8'(m));
        if (mode !== m) end_sim();
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'h0;
        step(4);
        wait_mode(supply_pkg::MODE_NORMAL, 5);
        chk({rb, ext, pco}, 8'h35);
        i_host_model.drive(1'h0, 1'h0, 4'h0);
        step(5);
        chk({c_oe, c_lvl}, 8'h03);
        @(posedge mclk) wake <= 1'h0;
        step(3);
        chk({c_oe, 5'(mode)}, 8'(supply_pkg::MODE_SLEEP));
        @(posedge mclk) {wake, by_rst} <= 2'h3;
        step(4);
        chk(c_oe, 8'h00);
        @(posedge mclk) by_rst <= 1'h0;
        step(4);
        chk(c_lvl, 8'h01);
        @(posedge mclk) fev <= 8'hff;
        @(posedge mclk) fev <= 8'h00;
        step(3);
        chk(fst, 8'hff);
        @(posedge mclk) bat <= 1'h0;
        step(3);
        chk({c_oe, ext, pco}, 8'h10);
        chk(fst, 8'hff);
        @(posedge mclk) vcc <= 1'h0;
        step(3);
        chk({ext, pco, fst}, 16'h0000);
        @(posedge mclk) {bat, vcc, gnd} <= 3'h6;
        i_host_model.drive(1'h1, 1'h0, 4'h0);
        step(5);
        chk(pco, 8'h00);
        @(posedge mclk) {gnd, vcc} <= 2'h2;
        step(3);
        chk({rb, wdt, dst}, 8'h06);
        @(posedge mclk) vcc <= 1'h1;
        wait_mode(supply_pkg::MODE_NORMAL, 10);
        @(posedge mclk) spi_err <= 1'h1;
        @(posedge mclk) spi_err <= 1'h0;
        wait_mode(supply_pkg::MODE_FAIL, 4);
        wait_mode(supply_pkg::MODE_NORMAL, 10);
        i_host_model.drive(1'h1, 1'h1, 4'ha);
        step(100);
        chk({dst[0], pco}, 8'h15);
        step(supply_pkg::FAIL_DGL_CYCLES - 100);
        chk(8'(mode), 8'(supply_pkg::MODE_NORMAL));
        wait_mode(supply_pkg::MODE_FAIL, 10);
        step(3);
        chk(pco, 8'h0a);
        i_host_model.drive(1'h1, 1'h1, 4'h3);
        step(5);
        chk(pco, 8'h03);
        end_sim();
    end
endmodule // supply_and_fail_mode_control_bench
